// File: logic/srma_core.sv
// register-mode serial front end and register map of the acquisition converter
// How it works
// - instruction msb zero means register access
// - bit six one reads, zero writes
// - bit five one means two bytes
// - five low bits give register address
// - even address: second byte at address plus one
// - odd address: second byte at address minus one
// - result split: high byte reg1, low reg0
// - single-byte write to reg0 resets device
// - reg2 holds six limit flags, top zero
// - reg3 holds binary, readback, divider fields
// - reg4 holds gain code and channel
// - bit7 regs 4,5: write converts, read busy
// - reg5 low nibble shows port pins
// - reg6 low nibble sets pin directions
// - reg7 holds oscillator, reference, level bits
// - reg24 holds mirrored serial format bits
// - reg31 returns fixed identity code
// - pin or reg0 reset clears registers, powers down
// - chip select high resets serial only
// - after reg0 reset wait for one bit
// - two-byte write commits both bytes together
// - read data captured at last active edge of preceding byte
// - conversion starts 2nd divided clock falling edge
`timescale 1ns/10ps
`include "srma_map.svh"
module srma_core #(
  parameter logic [7:0] ID_CODE = 8'h5A // arbitrary identity value
) (
  input wire logic mclk_in,
  input wire logic reset_in, // reset pin and power-on, async
  input wire logic cs_n_in, // serial chip select pin
  input wire logic sclk_in, // serial clock pin
  input wire logic sdi_in, // serial data pin
  input wire logic clk_edge_rise_in, // active edge select pin
  input wire logic div_clk_in, // divided conversion clock pin
  input wire logic [13:0] result_in, // conversion result
  input wire logic overrange_flag_in,
  input wire logic [5:0] amp_limit_flag_in,
  input wire logic conv_busy_in, // converter busy from analog side
  input wire logic [3:0] port_pin_in, // port pin levels
  output logic sdo_out, // serial data out
  output logic sdo_oe_out, // high while driving data out
  output logic sdi_drv_out, // two-wire read-back on data pin
  output logic sdi_drv_oe_out,
  output logic conv_start_out, // one-cycle conversion start pulse
  output logic [3:0] port_pin_out,
  output logic [3:0] port_pin_oe_out,
  output logic straight_code_select_out,
  output logic [1:0] auto_readback_mode_out,
  output logic [1:0] conv_clock_divider_out,
  output logic [2:0] gain_code_out,
  output logic [3:0] input_channel_select_out,
  output logic [5:0] ref_osc_out, // run, osc, vref, buffer, high, low
  output logic lsb_first_out,
  output logic two_wire_select_out,
  output logic alt_timing_out
);
  import srma_pkg::*;
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [4:0] pins_s; // cs (inverted so reset reads deselected), sclk, sdi, edge select, div clock
  logic [3:0] port_s;
  srma_sync3 #(.WIDTH(5)) u_sync_ser (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .pin_in({~cs_n_in, sclk_in, sdi_in, clk_edge_rise_in, div_clk_in}),
    .level_out(pins_s)
  );
  srma_sync3 #(.WIDTH(4)) u_sync_port (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .pin_in(port_pin_in),
    .level_out(port_s)
  );
  wire cs_n_s = ~pins_s[4];
  wire sclk_s = pins_s[3];
  wire sdi_s = pins_s[2];
  wire rise_s = pins_s[1];
  wire divided_conversion_clock_s = pins_s[0];
  // ****************************************************************
  // edge detection on filtered serial clock
  // ****************************************************************
  logic sclk_d_r; // previous filtered clock
  logic divided_conversion_clock_d_r;
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire act_edge = ~cs_n_s & (rise_s ? sclk_rise : sclk_fall);
  wire idle_edge = ~cs_n_s & (rise_s ? sclk_fall : sclk_rise);
  wire divided_conversion_clock_fall = ~divided_conversion_clock_s & divided_conversion_clock_d_r;
  // ****************************************************************
  // registers
  // ****************************************************************
  srma_state_type state_r;
  srma_state_type state_nxt;
  logic [7:0] shift_r; // serial shift register
  logic [2:0] bit_cnt_r; // bits seen in current byte
  logic [4:0] addr_r; // instruction address
  logic read_r;
  logic two_byte_r;
  logic second_r; // working on second byte
  logic [7:0] first_byte_r; // held until the pair commits
  logic [7:0] tx_r; // outgoing byte
  logic [7:0] conv_ctrl_r;
  logic [7:0] gain_chan_r;
  logic [3:0] port_out_r;
  logic [3:0] port_dir_r;
  logic [7:0] ref_osc_r;
  logic [7:0] ser_fmt_r;
  logic soft_reset_r; // pulse from register-0 write
  logic conv_req_r; // start requested, awaiting clock edges
  logic [1:0] divided_conversion_clock_cnt_r;
  logic conv_start_r;
  // ****************************************************************
  // decode of the arriving bit and instruction fields
  // ****************************************************************
  wire lsb_first = ser_fmt_r[0];
  // lsb-first fills from the top so the byte lands in order
  wire [7:0] shift_nxt = lsb_first ? {sdi_s, shift_r[7:1]} : {shift_r[6:0], sdi_s};
  wire byte_done = act_edge & (bit_cnt_r == 3'h7);
  wire ins_regmode = ~shift_nxt[`SRMA_INS_MODE_BIT];
  wire ins_read = shift_nxt[`SRMA_INS_READ_BIT];
  wire ins_two = shift_nxt[`SRMA_INS_LEN_BIT];
  wire [4:0] ins_addr = shift_nxt[`SRMA_INS_ADDR_HI:0];
  // reg0 single-byte write resets at once, no data awaited
  wire reset_cmd = (state_r == SRMA_INSTR) & byte_done & ins_regmode & ~ins_read & ~ins_two
    & (ins_addr == `SRMA_ADDR_RESULT_LOW);
  // second byte address: even plus one, odd minus one
  wire [4:0] pair_addr = addr_r[0] ? addr_r - 5'h01 : addr_r + 5'h01;
  wire [4:0] cur_addr = second_r ? pair_addr : addr_r;
  wire dev_reset = reset_in; // async part; soft reset handled synchronously
  // ****************************************************************
  // read multiplexer
  // ****************************************************************
  function automatic logic [7:0] read_reg(input logic [4:0] a);
    logic [7:0] v;
    v = `SRMA_ZERO_BYTE;
    unique case (a)
      `SRMA_ADDR_RESULT_LOW: v = {result_in[5:0], 1'b0, overrange_flag_in};
      `SRMA_ADDR_RESULT_HIGH: v = result_in[13:6];
      `SRMA_ADDR_LIMIT_FLAGS: v = {2'b00, amp_limit_flag_in};
      `SRMA_ADDR_CONV_CTRL: v = conv_ctrl_r;
      `SRMA_ADDR_GAIN_CHAN: v = {conv_busy_in | conv_req_r, gain_chan_r[6:0]};
      `SRMA_ADDR_PORT_STATE: v = {conv_busy_in | conv_req_r, 3'b000, port_s};
      `SRMA_ADDR_PORT_DIR: v = {4'h0, port_dir_r};
      `SRMA_ADDR_REF_OSC: v = ref_osc_r;
      `SRMA_ADDR_SER_FMT: v = ser_fmt_r;
      `SRMA_ADDR_IDENTITY: v = ID_CODE;
      default: v = `SRMA_ZERO_BYTE;
    endcase
    return v;
  endfunction : read_reg
  // ****************************************************************
  // serial state machine, next state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SRMA_SYNC: begin
        // wait for a one as synchronising bit
        if (act_edge && sdi_s) begin
          state_nxt = SRMA_INSTR;
        end
      end
      SRMA_INSTR: begin
        if (byte_done) begin
          if (!ins_regmode || reset_cmd) begin
            state_nxt = reset_cmd ? SRMA_SYNC : SRMA_INSTR;
          end else begin
            state_nxt = ins_read ? SRMA_RDATA : SRMA_WDATA;
          end
        end
      end
      SRMA_WDATA, SRMA_RDATA: begin
        if (byte_done && (!two_byte_r || second_r)) begin
          state_nxt = SRMA_INSTR;
        end
      end
      default: state_nxt = SRMA_INSTR;
    endcase
  end
  // ****************************************************************
  // serial shift, counters and transfer bookkeeping
  // ****************************************************************
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= SRMA_INSTR;
      shift_r <= `SRMA_ZERO_BYTE;
      bit_cnt_r <= 3'h0;
      addr_r <= 5'h00;
      read_r <= 1'b0;
      two_byte_r <= 1'b0;
      second_r <= 1'b0;
      first_byte_r <= `SRMA_ZERO_BYTE;
      sclk_d_r <= 1'b0;
      divided_conversion_clock_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      divided_conversion_clock_d_r <= divided_conversion_clock_s;
      if (cs_n_s) begin
        // chip select high: serial side only, registers kept
        state_r <= SRMA_INSTR;
        bit_cnt_r <= 3'h0;
        second_r <= 1'b0;
      end else if (act_edge) begin
        state_r <= state_nxt;
        shift_r <= shift_nxt;
        // sync bit is not counted as instruction data
        bit_cnt_r <= (state_r == SRMA_SYNC) ? 3'h0 : bit_cnt_r + 3'h1;
        if (state_r == SRMA_INSTR && byte_done) begin
          addr_r <= ins_addr;
          read_r <= ins_read;
          two_byte_r <= ins_two;
          second_r <= 1'b0;
        end else if (byte_done && two_byte_r && !second_r) begin
          first_byte_r <= shift_nxt;
          second_r <= 1'b1;
        end else if (byte_done) begin
          second_r <= 1'b0;
        end
      end
    end
  end
  // ****************************************************************
  // write commit: one byte, or both of a pair in the same cycle
  // ****************************************************************
  wire commit = (state_r == SRMA_WDATA) & byte_done & (!two_byte_r | second_r);
  wire [7:0] wr_a_data = two_byte_r ? first_byte_r : shift_nxt;
  wire [4:0] wr_b_addr = pair_addr;
  wire wr_b_en = commit & two_byte_r;
  // read-only and unlisted addresses simply match nothing here
  function automatic logic hit(input logic [4:0] reg_addr);
    return commit & (addr_r == reg_addr) | wr_b_en & (wr_b_addr == reg_addr);
  endfunction : hit
  function automatic logic [7:0] wdat(input logic [4:0] reg_addr);
    return (commit & (addr_r == reg_addr)) ? wr_a_data : shift_nxt;
  endfunction : wdat
  wire [7:0] wd_gain = wdat(`SRMA_ADDR_GAIN_CHAN);
  wire [7:0] wd_port = wdat(`SRMA_ADDR_PORT_STATE);
  wire [7:0] wd_dir = wdat(`SRMA_ADDR_PORT_DIR);
  wire conv_write = (hit(`SRMA_ADDR_GAIN_CHAN) & wd_gain[`SRMA_CONVERT_BIT])
    | (hit(`SRMA_ADDR_PORT_STATE) & wd_port[`SRMA_CONVERT_BIT]);
  // ****************************************************************
  // register file; soft reset clears it like the reset pin
  // ****************************************************************
  always_ff @(posedge mclk_in or posedge dev_reset) begin
    if (dev_reset) begin
      conv_ctrl_r <= `SRMA_ZERO_BYTE;
      gain_chan_r <= `SRMA_ZERO_BYTE;
      port_out_r <= 4'h0;
      port_dir_r <= 4'h0;
      ref_osc_r <= `SRMA_ZERO_BYTE;
      ser_fmt_r <= `SRMA_ZERO_BYTE;
      soft_reset_r <= 1'b0;
    end else if (soft_reset_r) begin
      conv_ctrl_r <= `SRMA_ZERO_BYTE;
      gain_chan_r <= `SRMA_ZERO_BYTE;
      port_out_r <= 4'h0;
      port_dir_r <= 4'h0;
      ref_osc_r <= `SRMA_ZERO_BYTE;
      ser_fmt_r <= `SRMA_ZERO_BYTE;
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= reset_cmd & ~cs_n_s;
      if (hit(`SRMA_ADDR_CONV_CTRL)) begin
        conv_ctrl_r <= wdat(`SRMA_ADDR_CONV_CTRL) & `SRMA_CONV_CTRL_MASK;
      end
      if (hit(`SRMA_ADDR_GAIN_CHAN)) begin
        gain_chan_r <= wd_gain & `SRMA_GAIN_CHAN_MASK;
      end
      if (hit(`SRMA_ADDR_PORT_STATE)) begin
        port_out_r <= wd_port[3:0];
      end
      if (hit(`SRMA_ADDR_PORT_DIR)) begin
        port_dir_r <= wd_dir[3:0];
      end
      if (hit(`SRMA_ADDR_REF_OSC)) begin
        ref_osc_r <= wdat(`SRMA_ADDR_REF_OSC) & `SRMA_REF_OSC_MASK;
      end
      if (hit(`SRMA_ADDR_SER_FMT)) begin
        ser_fmt_r <= wdat(`SRMA_ADDR_SER_FMT) & `SRMA_SER_FMT_MASK;
      end
    end
  end
  // ****************************************************************
  // read data: snapshot at last active edge of the byte before each data byte
  // ****************************************************************
  wire load_tx = (state_r == SRMA_INSTR) & byte_done & ins_regmode & ins_read;
  wire load_tx2 = (state_r == SRMA_RDATA) & byte_done & two_byte_r & ~second_r;
  // a snapshot at the byte boundary stands for the first edge of the byte
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_r <= `SRMA_ZERO_BYTE;
      sdo_out <= 1'b0;
    end else begin
      if (load_tx) begin
        tx_r <= read_reg(ins_addr);
      end else if (load_tx2) begin
        tx_r <= read_reg(pair_addr);
      end else if (idle_edge && state_r == SRMA_RDATA) begin
        // data moves on the inactive edge
        sdo_out <= lsb_first ? tx_r[0] : tx_r[7];
        tx_r <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
      end
    end
  end
  // ****************************************************************
  // conversion start: second falling divided clock edge after write
  // ****************************************************************
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      conv_req_r <= 1'b0;
      divided_conversion_clock_cnt_r <= 2'h0;
      conv_start_r <= 1'b0;
    end else begin
      conv_start_r <= 1'b0;
      if (conv_write) begin
        conv_req_r <= 1'b1;
        divided_conversion_clock_cnt_r <= 2'h0;
      end else if (conv_req_r && divided_conversion_clock_fall) begin
        if (divided_conversion_clock_cnt_r + 2'h1 == `SRMA_START_EDGES) begin
          conv_req_r <= 1'b0;
          conv_start_r <= 1'b1;
        end
        divided_conversion_clock_cnt_r <= divided_conversion_clock_cnt_r + 2'h1;
      end
    end
  end
  // ****************************************************************
  // outputs
  // ****************************************************************
  wire cur_unused = ^cur_addr;
  assign sdo_oe_out = ~cs_n_s | (cur_unused & 1'b0);
  assign sdi_drv_out = sdo_out;
  assign sdi_drv_oe_out = two_wire_select_out & (state_r == SRMA_RDATA) & ~cs_n_s;
  assign conv_start_out = conv_start_r;
  assign port_pin_out = port_out_r;
  assign port_pin_oe_out = port_dir_r;
  assign straight_code_select_out = conv_ctrl_r[5];
  assign auto_readback_mode_out = conv_ctrl_r[3:2];
  assign conv_clock_divider_out = conv_ctrl_r[1:0];
  assign gain_code_out = gain_chan_r[6:4];
  assign input_channel_select_out = gain_chan_r[3:0];
  assign ref_osc_out = ref_osc_r[5:0];
  assign lsb_first_out = ser_fmt_r[0];
  assign two_wire_select_out = ser_fmt_r[1];
  assign alt_timing_out = ser_fmt_r[2];
endmodule : srma_core

// File: logic/srma_map.svh
// register offsets, field positions and timing constants of the serial register block
`ifndef SRMA_MAP_SVH
`define SRMA_MAP_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define SRMA_ADDR_RESULT_LOW 5'h00
`define SRMA_ADDR_RESULT_HIGH 5'h01
`define SRMA_ADDR_LIMIT_FLAGS 5'h02
`define SRMA_ADDR_CONV_CTRL 5'h03
`define SRMA_ADDR_GAIN_CHAN 5'h04
`define SRMA_ADDR_PORT_STATE 5'h05
`define SRMA_ADDR_PORT_DIR 5'h06
`define SRMA_ADDR_REF_OSC 5'h07
`define SRMA_ADDR_SER_FMT 5'h18
`define SRMA_ADDR_IDENTITY 5'h1F
// ****************************************************************
// instruction byte fields
// ****************************************************************
`define SRMA_INS_MODE_BIT 7
`define SRMA_INS_READ_BIT 6
`define SRMA_INS_LEN_BIT 5
`define SRMA_INS_ADDR_HI 4
// ****************************************************************
// register fields and masks
// ****************************************************************
`define SRMA_CONVERT_BIT 7
`define SRMA_CONV_CTRL_MASK 8'h2F
`define SRMA_GAIN_CHAN_MASK 8'h7F
`define SRMA_PORT_MASK 8'h0F
`define SRMA_REF_OSC_MASK 8'h3F
`define SRMA_SER_FMT_MASK 8'hE7
`define SRMA_LIMIT_MASK 8'h3F
`define SRMA_ZERO_BYTE 8'h00
// ****************************************************************
// timing: conversion starts on 2nd divided clock falling edge
// ****************************************************************
`define SRMA_START_EDGES 2'h2
`endif

// File: logic/srma_pkg.sv
// types shared by the serial register block
package srma_pkg;
  // serial front end states, one-hot
  typedef enum logic [3:0] {
    SRMA_SYNC = 4'h1,
    SRMA_INSTR = 4'h2,
    SRMA_WDATA = 4'h4,
    SRMA_RDATA = 4'h8
  } srma_state_type;
endpackage : srma_pkg

// File: logic/srma_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module srma_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_r; // first stage, read by s2 only
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_r;
  // ****************************************************************
  // per-bit chain: level changes once stages two and three agree
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
          level_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= pin_in[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) begin
            level_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate
  assign level_out = level_r;
endmodule : srma_sync3

// File: verification/srma_core_assertions.sv
// concurrent checks bound onto the serial register block ports
`timescale 1ns/10ps
module srma_core_chk (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic cs_n_in,
  input wire logic div_clk_in,
  input wire logic sdo_oe_out,
  input wire logic sdi_drv_oe_out,
  input wire logic two_wire_select_out,
  input wire logic conv_start_out,
  input wire logic [2:0] gain_code_out,
  input wire logic [3:0] input_channel_select_out,
  input wire logic [3:0] port_pin_out,
  input wire logic [3:0] port_pin_oe_out,
  input wire logic [5:0] ref_osc_out
);
  // ****************************************
  // stored configuration seen at the pins
  // ****************************************
  logic [20:0] cfg; // gathered so one check covers the gain, channel, port pin, pin direction and reference fields
  assign cfg = {gain_code_out, input_channel_select_out, port_pin_out, port_pin_oe_out, ref_osc_out};
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  // chip select held long enough to pass the pin synchroniser
  sequence cs_idle;
    cs_n_in [*8];
  endsequence
  sequence cs_busy;
    !cs_n_in [*8];
  endsequence
  reset_clear_a: assert property ($fell(reset_in) |-> cfg == 21'h0 && !conv_start_out)
    else $error("configuration not cleared by reset");
  oe_follow_cs_a: assert property (cs_busy |-> sdo_oe_out)
    else $error("data out not driven while selected");
  oe_drop_cs_a: assert property (cs_idle |-> !sdo_oe_out && !sdi_drv_oe_out)
    else $error("data pins driven while deselected");
  cs_hold_cfg_a: assert property (cs_idle |-> $stable(cfg))
    else $error("configuration changed while deselected");
  cfg_needs_cs_a: assert property ($changed(cfg) |-> !$past(cs_n_in, 4))
    else $error("configuration changed without a serial frame");
  start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
    else $error("conversion start longer than one cycle");
  start_divided_conversion_clock_a: assert property (conv_start_out |-> !div_clk_in && $past(div_clk_in, 8))
    else $error("conversion start not after divided clock fall");
  two_wire_oe_a: assert property (sdi_drv_oe_out |-> two_wire_select_out && sdo_oe_out)
    else $error("data in pin driven outside two-wire read");
endmodule : srma_core_chk
bind srma_core srma_core_chk u_srma_core_chk (
  .mclk_in(mclk_in), .reset_in(reset_in), .cs_n_in(cs_n_in), .div_clk_in(div_clk_in),
  .sdo_oe_out(sdo_oe_out), .sdi_drv_oe_out(sdi_drv_oe_out), .two_wire_select_out(two_wire_select_out),
  .conv_start_out(conv_start_out), .gain_code_out(gain_code_out),
  .input_channel_select_out(input_channel_select_out), .port_pin_out(port_pin_out),
  .port_pin_oe_out(port_pin_oe_out), .ref_osc_out(ref_osc_out)
);

// File: verification/srma_host_model.sv
// host serial master model driving chip select, serial clock and data
`timescale 1ns/10ps
module srma_host_model (
  input wire logic mclk_in,
  input wire logic sdo_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic sdi_out
);
  logic lsb_first; // host shift order, kept equal to the format register
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    lsb_first = 1'b0;
  end
  // ****************************************
  // bit and frame tasks
  // ****************************************
  // half serial period, slow enough for the pin synchronisers
  task automatic half();
    repeat (8) @(negedge mclk_in);
  endtask : half
  // data set while clock low, reply sampled at the rising edge
  task automatic sbit(input logic b, output logic r);
    sdi_out = b;
    half();
    r = sdo_in;
    sclk_out = 1'b1;
    half();
    sclk_out = 1'b0;
  endtask : sbit
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    logic r;
    for (int i = 0; i < 8; i++) begin
      sbit(tx[lsb_first ? i : 7 - i], r);
      rx[lsb_first ? i : 7 - i] = r;
    end
  endtask : xbyte
  // optional resync string, instruction, then nb data bytes; clock stands still outside
  task automatic frame(input logic [7:0] ins, input logic [15:0] wd, input int pre, input int nb,
                       output logic [15:0] rd);
    logic r;
    rd = 16'h0000;
    cs_n_out = 1'b0;
    half();
    if (pre > 0) begin
      repeat (pre) sbit(1'b0, r);
      sbit(1'b1, r);
    end
    xbyte(ins, rd[7:0]);
    if (nb > 0) xbyte(wd[15:8], rd[15:8]);
    if (nb > 1) xbyte(wd[7:0], rd[7:0]);
    half();
    cs_n_out = 1'b1;
    half();
  endtask : frame
endmodule : srma_host_model

// File: verification/tb_top.sv
// self-checking bench for the serial register block
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] ID = 8'h3C; // arbitrary identity value
  logic mclk_in, reset_in, cs_n, sclk, sdi, div_clk, busy, overrange_flag, sdo, sdo_oe, start, straight_code_select, lsbf, tws, alt;
  logic [13:0] res;
  logic [5:0] lim, ros;
  logic [3:0] pin, pout, poe, chan;
  logic [2:0] gain;
  logic [1:0] arb, cdiv;
  logic [7:0] shd [32];
  logic [4:0] ra [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h18, 5'h1F};
  logic [4:0] wa [5] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07};
  logic [4:0] ro [4] = '{5'h02, 5'h08, 5'h1F, 5'h01};
  logic [4:0] a;
  logic [15:0] d, r;
  logic sdo_w; // undriven data out shows the inverted sdo level, never the driven one
  int bad_count = 0, num_checks = 0, starts = 0, n, k, w, seed;
  assign sdo_w = sdo_oe ? sdo : ~sdo;
  srma_core #(.ID_CODE(ID)) u_srma_core (
    .mclk_in(mclk_in), .reset_in(reset_in), .cs_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi),
    .clk_edge_rise_in(1'b1), .div_clk_in(div_clk), .result_in(res), .overrange_flag_in(overrange_flag),
    .amp_limit_flag_in(lim), .conv_busy_in(busy), .port_pin_in(pin), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .sdi_drv_out(), .sdi_drv_oe_out(), .conv_start_out(start), .port_pin_out(pout), .port_pin_oe_out(poe),
    .straight_code_select_out(straight_code_select), .auto_readback_mode_out(arb), .conv_clock_divider_out(cdiv),
    .gain_code_out(gain), .input_channel_select_out(chan), .ref_osc_out(ros), .lsb_first_out(lsbf),
    .two_wire_select_out(tws), .alt_timing_out(alt));
  srma_host_model u_srma_host_model (.mclk_in(mclk_in), .sdo_in(sdo_w), .cs_n_out(cs_n),
    .sclk_out(sclk), .sdi_out(sdi));
  // ****************************************
  // clocks and watchdog
  // ****************************************
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // divided conversion clock, free running at sixteen system cycles
  initial begin
    div_clk = 1'b0;
    forever begin
      repeat (8) @(negedge mclk_in);
      div_clk = ~div_clk;
    end
  end
  always @(posedge mclk_in) if (start === 1'b1) starts++;
  initial begin
    repeat (90000) @(posedge mclk_in);
    bad_count++;
    give_verdict();
  end
  // ****************************************
  // expectations and helpers
  // ****************************************
  function automatic logic [7:0] msk(input logic [4:0] x);
    case (x)
      5'h03: msk = 8'h2F;
      5'h04: msk = 8'h7F;
      5'h05, 5'h06: msk = 8'h0F;
      5'h07: msk = 8'h3F;
      5'h18: msk = 8'hE7;
      default: msk = 8'h00;
    endcase
  endfunction : msk
  function automatic logic [7:0] exp_rd(input logic [4:0] x);
    case (x)
      5'h00: exp_rd = {res[5:0], 1'b0, overrange_flag};
      5'h01: exp_rd = res[13:6];
      5'h02: exp_rd = {2'b00, lim};
      5'h04: exp_rd = {busy, shd[4][6:0]};
      5'h05: exp_rd = {busy, 3'b000, pin};
      5'h1F: exp_rd = ID;
      default: exp_rd = shd[x];
    endcase
  endfunction : exp_rd
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic chk_cfg(input string what);
    chk(what, {shd[3][5], shd[3][3:0], shd[4][6:0], shd[5][3:0], shd[6][3:0], shd[7][5:0], shd[24][2:0]},
        {straight_code_select, arb, cdiv, gain, chan, pout, poe, ros, alt, tws, lsbf});
  endtask : chk_cfg
  task automatic wr(input logic [4:0] x, input logic [15:0] v, input int nb);
    logic [15:0] q;
    u_srma_host_model.frame({2'b00, nb == 2, x}, v, 0, nb, q);
    shd[x] = v[15:8] & msk(x);
    if (nb == 2) shd[x ^ 5'h01] = v[7:0] & msk(x ^ 5'h01);
  endtask : wr
  task automatic rd(input logic [4:0] x, input int nb);
    logic [15:0] q;
    u_srma_host_model.frame({2'b01, nb == 2, x}, 16'h0000, 0, nb, q);
    chk("first read byte", {24'h0, exp_rd(x)}, {24'h0, q[15:8]});
    if (nb == 2) chk("second read byte", {24'h0, exp_rd(x ^ 5'h01)}, {24'h0, q[7:0]});
  endtask : rd
  task automatic stir();
    res = 14'($urandom);
    overrange_flag = 1'($urandom);
    lim = 6'($urandom);
    busy = 1'($urandom);
    pin = 4'($urandom);
  endtask : stir
  task automatic clr();
    for (int i = 0; i < 32; i++) shd[i] = 8'h00;
  endtask : clr
  task automatic done(input string s);
    $display("test %s ended", s);
  endtask : done
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset_in = 1'b1;
    seed = $urandom(7);
    stir();
    clr();
    repeat (16) @(negedge mclk_in);
    reset_in = 1'b0;
    repeat (8) @(negedge mclk_in);
    foreach (ra[i]) rd(ra[i], 1);
    chk_cfg("reset outputs");
    done("reset values");
    for (int i = 0; i < 24; i++) begin
      a = wa[$urandom_range(4, 0)];
      n = $urandom_range(2, 1);
      d = 16'($urandom) & 16'h7F7F;
      if (a == 5'h03) d[15:8] = d[15:8] & 8'h3F;
      stir();
      wr(a, d, n);
      rd(a, n);
      chk_cfg("config outputs");
    end
    for (int i = 0; i < 2; i++) rd(5'(i), 2);
    done("random access");
    foreach (ro[i]) wr(ro[i], 16'hFFFF, (ro[i] == 5'h01) ? 2 : 1);
    chk_cfg("read-only writes");
    u_srma_host_model.frame(8'h26, {~shd[6], ~shd[7]}, 0, 1, r);
    chk_cfg("aborted pair");
    done("refused writes");
    busy = 1'b0;
    for (int i = 4; i < 6; i++) begin
      k = starts;
      wr(5'(i), {1'b1, shd[i][6:0], 8'h00}, 1);
      for (w = 0; w < 200 && starts == k; w++) @(negedge mclk_in);
      repeat (40) @(negedge mclk_in);
      chk("convert pulses", 32'h1, starts - k);
    end
    done("convert");
    wr(5'h18, 16'h8300, 1);
    u_srma_host_model.lsb_first = 1'b1;
    rd(5'h18, 1);
    chk_cfg("bit order");
    wr(5'h18, 16'h0000, 1);
    u_srma_host_model.lsb_first = 1'b0;
    done("bit order");
    wr(5'h03, 16'h2F00, 1);
    u_srma_host_model.frame(8'h43, 16'h0000, 39, 1, r);
    clr();
    chk("resync read", 32'h0, {24'h0, r[15:8]});
    chk_cfg("resync clear");
    wr(5'h07, 16'h3F00, 1);
    reset_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    reset_in = 1'b0;
    clr();
    repeat (8) @(negedge mclk_in);
    chk_cfg("pin reset");
    rd(5'h07, 1);
    done("resets");
    give_verdict();
  end
endmodule : tb_top
